// file: slave_map.svh
`ifndef SLAVE_MAP_SVH
`define SLAVE_MAP_SVH

// ***************************************************************
// Byte and address layout
// ***************************************************************
`define SLV_BYTE_BITS 4'h8
`define SLV_CNT_ZERO 4'h0
`define SLV_CNT_ONE 4'h1
`define SLV_LAST_TX_RISE 4'h7
`define SLV_BYTE_ZERO 8'h00
`define SLV_TEN_PREFIX 5'h1E
`define SLV_PREFIX_MSB 7
`define SLV_PREFIX_LSB 3
`define SLV_ADDR_MSB 7
`define SLV_ADDR_LSB 1
`define SLV_RW_BIT 0
`define SLV_TX_BIT 7

// ***************************************************************
// Crossing lanes
// ***************************************************************
`define SLV_NUM_EV 4
`define SLV_EV_RISE 0
`define SLV_EV_FALL 1
`define SLV_EV_START 2
`define SLV_EV_STOP 3
`define SLV_NUM_LV 2
`define SLV_LV_SCL 0
`define SLV_LV_SDA 1

`endif

// file: slave_pkg.sv
`default_nettype none
package slave_pkg;
  typedef logic [7:0] byte_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_TX_NEXT,
    ST_IGNORE
  } eng_state_t;

  typedef enum logic [1:0] {
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_DATA
  } phase_t;

  typedef struct packed {
    eng_state_t st;
    phase_t phase;
    logic [3:0] bitcnt;
    byte_t shift;
    byte_t buffer;
    byte_t own_addr;
    logic bf;
    logic ov;
    logic irq;
    logic ua;
    logic ua_hold;
    logic rw;
    logic clock_release_bit;
    logic acked;
    logic tx_next;
    logic addr_byte;
    logic hi_match;
    logic scl_oe;
    logic sda_oe;
    logic pin_lvl;
  } eng_t;

  typedef struct packed {
    logic scl_d;
    logic sda_d;
  } link_t;
endpackage
`default_nettype wire

// file: cdc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module cdc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t sync_r;
  sync_t sync_nxt;

  always_comb begin
    sync_nxt.s1 = d_i;
    sync_nxt.s2 = sync_r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_r <= '0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign q_o = sync_r.s2;
endmodule // cdc_sync
`default_nettype wire

// file: event_cross.sv
`timescale 1ns/100ps
`default_nettype none
module event_cross #(
  parameter int WIDTH = 1
) (
  input wire logic src_clk_i,
  input wire logic src_rst_i,
  input wire logic [WIDTH-1:0] ev_i,
  input wire logic dst_clk_i,
  input wire logic dst_rst_i,
  output logic [WIDTH-1:0] ev_o
);
  typedef struct packed {
    logic [WIDTH-1:0] tgl;
  } src_t;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } dst_t;

  src_t src_r;
  src_t src_nxt;
  dst_t dst_r;
  dst_t dst_nxt;

  // ***************************************************************
  // Toggle per event on the source side
  // ***************************************************************
  always_comb begin
    src_nxt.tgl = src_r.tgl ^ ev_i;
  end

  always_ff @(posedge src_clk_i) begin
    if (src_rst_i) begin
      src_r <= '0;
    end else begin
      src_r <= src_nxt;
    end
  end

  // ***************************************************************
  // Two stages, then edge of the toggle
  // ***************************************************************
  always_comb begin
    dst_nxt.s1 = src_r.tgl;
    dst_nxt.s2 = dst_r.s1;
    dst_nxt.s3 = dst_r.s2;
  end

  always_ff @(posedge dst_clk_i) begin
    if (dst_rst_i) begin
      dst_r <= '0;
    end else begin
      dst_r <= dst_nxt;
    end
  end

  assign ev_o = dst_r.s2 ^ dst_r.s3;
endmodule // event_cross
`default_nettype wire

// file: i2c_slave_addr_and_clock_stretch.sv
`timescale 1ns/100ps
`default_nettype none
`include "slave_map.svh"

module i2c_slave_addr_and_clock_stretch (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic LINK_CLK_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SCL_O,
  output logic SCL_OE_O,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic TEN_BIT_MODE_I,
  input wire logic STRETCH_ENABLE_I,
  input wire slave_pkg::byte_t OWN_ADDRESS_I,
  input wire logic OWN_ADDRESS_WR_I,
  input wire slave_pkg::byte_t TX_DATA_I,
  input wire logic TX_WR_I,
  input wire logic BUF_RD_I,
  input wire logic IRQ_CLR_I,
  input wire logic OVERFLOW_CLR_I,
  input wire logic CLOCK_RELEASE_SET_I,
  output slave_pkg::byte_t RX_DATA_O,
  output logic BUFFER_FULL_O,
  output logic OVERFLOW_O,
  output logic IRQ_FLAG_O,
  output logic UPDATE_ADDRESS_O,
  output logic READ_WRITE_O,
  output logic CLOCK_RELEASE_O,
  output slave_pkg::byte_t OWN_ADDRESS_O
);
  import slave_pkg::*;

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic link_rst;
  logic [1:0] pin_sync;
  link_t link_r, link_nxt;
  logic [`SLV_NUM_EV-1:0] link_ev, sys_ev;
  logic [`SLV_NUM_LV-1:0] link_lv, sys_lv;
  eng_t eng_r, eng_nxt;
  logic ev_rise, ev_fall, ev_start, ev_stop;
  logic scl_lvl, sda_lvl;

  // ***************************************************************
  // Link clock domain front end
  // ***************************************************************
  cdc_sync #(
    .WIDTH(1)
  ) u_link_rst (
    .clk_i(LINK_CLK_I),
    .rst_i(1'b0),
    .d_i(RST_I),
    .q_o(link_rst)
  );

  cdc_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk_i(LINK_CLK_I),
    .rst_i(1'b0),
    .d_i({SDA_I, SCL_I}),
    .q_o(pin_sync)
  );

  always_comb begin
    link_nxt.scl_d = pin_sync[`SLV_LV_SCL];
    link_nxt.sda_d = pin_sync[`SLV_LV_SDA];
  end

  always_ff @(posedge LINK_CLK_I) begin
    if (link_rst) begin
      link_r <= '1;
    end else begin
      link_r <= link_nxt;
    end
  end

  always_comb begin
    link_ev = '0;
    link_ev[`SLV_EV_RISE] = pin_sync[`SLV_LV_SCL] & ~link_r.scl_d;
    link_ev[`SLV_EV_FALL] = ~pin_sync[`SLV_LV_SCL] & link_r.scl_d;
    link_ev[`SLV_EV_START] = link_r.sda_d & ~pin_sync[`SLV_LV_SDA]
                             & pin_sync[`SLV_LV_SCL] & link_r.scl_d;
    link_ev[`SLV_EV_STOP] = ~link_r.sda_d & pin_sync[`SLV_LV_SDA]
                            & pin_sync[`SLV_LV_SCL] & link_r.scl_d;
    link_lv = pin_sync;
  end

  // ***************************************************************
  // Crossing into the system domain
  // ***************************************************************
  event_cross #(
    .WIDTH(`SLV_NUM_EV)
  ) u_ev_cross (
    .src_clk_i(LINK_CLK_I),
    .src_rst_i(link_rst),
    .ev_i(link_ev),
    .dst_clk_i(CLK_SYS_I),
    .dst_rst_i(RST_I),
    .ev_o(sys_ev)
  );

  cdc_sync #(
    .WIDTH(`SLV_NUM_LV)
  ) u_lv_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .d_i(link_lv),
    .q_o(sys_lv)
  );

  assign ev_rise = sys_ev[`SLV_EV_RISE];
  assign ev_fall = sys_ev[`SLV_EV_FALL];
  assign ev_start = sys_ev[`SLV_EV_START];
  assign ev_stop = sys_ev[`SLV_EV_STOP];
  assign scl_lvl = sys_lv[`SLV_LV_SCL];
  assign sda_lvl = sys_lv[`SLV_LV_SDA];

  // ***************************************************************
  // Slave engine
  // ***************************************************************
  always_comb begin
    logic hit;
    logic to_tx;
    logic set_ua;
    logic ack;
    logic want_hold;
    hit = 1'b0;
    to_tx = 1'b0;
    set_ua = 1'b0;
    ack = 1'b0;
    want_hold = 1'b0;
    eng_nxt = eng_r;
    eng_nxt.pin_lvl = 1'b0;

    // Software side
    if (OWN_ADDRESS_WR_I) begin
      eng_nxt.own_addr = OWN_ADDRESS_I;
      eng_nxt.ua = 1'b0;
      eng_nxt.ua_hold = 1'b0;
    end
    if (BUF_RD_I) begin
      eng_nxt.bf = 1'b0;
    end
    if (IRQ_CLR_I) begin
      eng_nxt.irq = 1'b0;
    end
    if (OVERFLOW_CLR_I) begin
      eng_nxt.ov = 1'b0;
    end
    if (CLOCK_RELEASE_SET_I) begin
      eng_nxt.clock_release_bit = 1'b1;
    end
    if (TX_WR_I) begin
      eng_nxt.buffer = TX_DATA_I;
      eng_nxt.bf = 1'b1;
      if (!(eng_r.st == ST_TX && eng_r.bitcnt != `SLV_CNT_ZERO)) begin
        eng_nxt.shift = TX_DATA_I;
      end
    end

    // Bus side
    if (ev_stop) begin
      eng_nxt.st = ST_IDLE;
      eng_nxt.sda_oe = 1'b0;
      eng_nxt.hi_match = 1'b0;
    end else if (ev_start) begin
      eng_nxt.st = ST_RX;
      eng_nxt.bitcnt = `SLV_CNT_ZERO;
      eng_nxt.phase = PH_ADDR_HI;
      eng_nxt.sda_oe = 1'b0;
    end else begin
      case (eng_r.st)
        ST_RX: begin
          if (ev_rise) begin
            eng_nxt.shift = {eng_r.shift[6:0], sda_lvl};
            eng_nxt.bitcnt = eng_r.bitcnt + `SLV_CNT_ONE;
          end else if (ev_fall && eng_r.bitcnt == `SLV_BYTE_BITS) begin
            case (eng_r.phase)
              PH_ADDR_HI: begin
                hit = eng_r.shift[`SLV_ADDR_MSB:`SLV_ADDR_LSB]
                      == eng_r.own_addr[`SLV_ADDR_MSB:`SLV_ADDR_LSB];
                to_tx = eng_r.shift[`SLV_RW_BIT];
                if (TEN_BIT_MODE_I) begin
                  if (eng_r.shift[`SLV_PREFIX_MSB:`SLV_PREFIX_LSB] != `SLV_TEN_PREFIX) begin
                    hit = 1'b0;
                  end
                  if (to_tx && !eng_r.hi_match) begin
                    hit = 1'b0;
                  end
                  set_ua = !to_tx;
                end
              end
              PH_ADDR_LO: begin
                hit = eng_r.shift == eng_r.own_addr;
                set_ua = 1'b1;
              end
              default: begin
                hit = 1'b1;
              end
            endcase
            ack = hit && !eng_r.bf && !eng_r.ov;
            if (!hit) begin
              eng_nxt.st = ST_IGNORE;
            end else begin
              eng_nxt.st = ST_ACK;
              eng_nxt.acked = ack;
              eng_nxt.tx_next = to_tx;
              eng_nxt.addr_byte = eng_r.phase != PH_DATA;
              if (ack) begin
                eng_nxt.buffer = eng_r.shift;
                eng_nxt.bf = 1'b1;
                eng_nxt.sda_oe = 1'b1;
              end else begin
                eng_nxt.ov = 1'b1;
              end
              if (eng_r.phase == PH_ADDR_HI) begin
                eng_nxt.rw = to_tx;
              end else if (eng_r.phase == PH_ADDR_LO) begin
                eng_nxt.rw = 1'b0;
              end
              if (set_ua) begin
                eng_nxt.ua = 1'b1;
              end
              if (eng_r.phase == PH_ADDR_HI && set_ua) begin
                eng_nxt.phase = PH_ADDR_LO;
              end else begin
                eng_nxt.phase = PH_DATA;
              end
              if (eng_r.phase == PH_ADDR_LO) begin
                eng_nxt.hi_match = 1'b1;
              end
            end
          end
        end
        ST_ACK: begin
          if (ev_fall) begin
            eng_nxt.sda_oe = 1'b0;
            eng_nxt.irq = 1'b1;
            eng_nxt.bitcnt = `SLV_CNT_ZERO;
            if (!eng_r.acked) begin
              eng_nxt.st = ST_IGNORE;
            end else if (eng_r.tx_next) begin
              eng_nxt.st = ST_TX;
              eng_nxt.clock_release_bit = 1'b0;
            end else begin
              eng_nxt.st = ST_RX;
              if (eng_r.addr_byte && eng_r.ua) begin
                eng_nxt.ua_hold = 1'b1;
              end else if (STRETCH_ENABLE_I && eng_r.bf
                           && !(TEN_BIT_MODE_I && eng_r.addr_byte)) begin
                eng_nxt.clock_release_bit = 1'b0;
              end
            end
          end
        end
        ST_TX: begin
          if (ev_rise) begin
            eng_nxt.bitcnt = eng_r.bitcnt + `SLV_CNT_ONE;
            if (eng_r.bitcnt == `SLV_LAST_TX_RISE) begin
              eng_nxt.bf = 1'b0;
            end
          end else if (ev_fall) begin
            if (eng_r.bitcnt == `SLV_BYTE_BITS) begin
              eng_nxt.st = ST_TX_ACK;
            end else if (eng_r.bitcnt != `SLV_CNT_ZERO) begin
              eng_nxt.shift = {eng_r.shift[6:0], 1'b0};
            end
          end
        end
        ST_TX_ACK: begin
          if (ev_rise) begin
            if (sda_lvl) begin
              eng_nxt.st = ST_IDLE;
              eng_nxt.rw = 1'b0;
              eng_nxt.ua = 1'b0;
              eng_nxt.bf = 1'b0;
              eng_nxt.hi_match = 1'b0;
              eng_nxt.irq = 1'b1;
            end else begin
              eng_nxt.st = ST_TX_NEXT;
            end
          end
        end
        ST_TX_NEXT: begin
          if (ev_fall) begin
            eng_nxt.irq = 1'b1;
            eng_nxt.st = ST_TX;
            eng_nxt.bitcnt = `SLV_CNT_ZERO;
            if (!eng_r.bf) begin
              eng_nxt.clock_release_bit = 1'b0;
            end
          end
        end
        default: begin
          eng_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // Transmit data drive while the byte is on the wire
    if (eng_nxt.st == ST_TX) begin
      eng_nxt.sda_oe = !eng_nxt.shift[`SLV_TX_BIT];
    end else if (eng_nxt.st != ST_ACK) begin
      eng_nxt.sda_oe = 1'b0;
    end

    // Clock hold only once the line is seen low
    want_hold = !eng_nxt.clock_release_bit || eng_nxt.ua_hold;
    eng_nxt.scl_oe = want_hold && (eng_r.scl_oe || !scl_lvl);
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      eng_r <= '{st: ST_IDLE, phase: PH_ADDR_HI, bitcnt: `SLV_CNT_ZERO,
                 shift: `SLV_BYTE_ZERO, buffer: `SLV_BYTE_ZERO,
                 own_addr: `SLV_BYTE_ZERO, clock_release_bit: 1'b1, default: 1'b0};
    end else begin
      eng_r <= eng_nxt;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign SCL_O = eng_r.pin_lvl;
  assign SDA_O = eng_r.pin_lvl;
  assign SCL_OE_O = eng_r.scl_oe;
  assign SDA_OE_O = eng_r.sda_oe;
  assign RX_DATA_O = eng_r.buffer;
  assign BUFFER_FULL_O = eng_r.bf;
  assign OVERFLOW_O = eng_r.ov;
  assign IRQ_FLAG_O = eng_r.irq;
  assign UPDATE_ADDRESS_O = eng_r.ua;
  assign READ_WRITE_O = eng_r.rw;
  assign CLOCK_RELEASE_O = eng_r.clock_release_bit;
  assign OWN_ADDRESS_O = eng_r.own_addr;
endmodule // i2c_slave_addr_and_clock_stretch
`default_nettype wire

// file: i2c_slave_addr_and_clock_stretch_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checker
// ****
module slave_checker (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic SCL_I,
  input wire logic SCL_OE_O,
  input wire logic SDA_OE_O,
  input wire logic BUF_RD_I,
  input wire logic IRQ_CLR_I,
  input wire logic OWN_ADDRESS_WR_I,
  input wire slave_pkg::byte_t OWN_ADDRESS_I,
  input wire slave_pkg::byte_t RX_DATA_O,
  input wire logic BUFFER_FULL_O,
  input wire logic OVERFLOW_O,
  input wire logic IRQ_FLAG_O,
  input wire logic UPDATE_ADDRESS_O,
  input wire logic READ_WRITE_O,
  input wire logic CLOCK_RELEASE_O,
  input wire slave_pkg::byte_t OWN_ADDRESS_O
);
  import slave_pkg::*;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  sequence s_hold_wait;
    ##[0:4] SCL_OE_O;
  endsequence
  sequence s_no_ack;
    (!SDA_OE_O && $stable(RX_DATA_O)) [*8];
  endsequence
  property p_scl_first;
    $rose(SCL_OE_O) |-> !SCL_I && !$past(SCL_I, 3);
  endproperty
  a_scl_first: assert property (p_scl_first) else $error("clock pulled while high");
  property p_release;
    $fell(SCL_OE_O) |-> CLOCK_RELEASE_O && !UPDATE_ADDRESS_O;
  endproperty
  a_release: assert property (p_release) else $error("clock freed too early");
  property p_ckp_hold;
    $fell(CLOCK_RELEASE_O) |-> s_hold_wait;
  endproperty
  a_ckp_hold: assert property (p_ckp_hold) else $error("clock not held");
  property p_irq_clr;
    $fell(IRQ_FLAG_O) |-> $past(IRQ_CLR_I);
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq fell by itself");
  property p_buf_rd;
    BUF_RD_I |=> !BUFFER_FULL_O;
  endproperty
  a_buf_rd: assert property (p_buf_rd) else $error("read kept full");
  property p_own_wr;
    OWN_ADDRESS_WR_I |=> OWN_ADDRESS_O == $past(OWN_ADDRESS_I) && !UPDATE_ADDRESS_O;
  endproperty
  a_own_wr: assert property (p_own_wr) else $error("address write lost");
  property p_ovf;
    $rose(OVERFLOW_O) |-> s_no_ack;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow byte taken");
  property p_ack_ok;
    $rose(SDA_OE_O) && !READ_WRITE_O |-> BUFFER_FULL_O && !OVERFLOW_O;
  endproperty
  a_ack_ok: assert property (p_ack_ok) else $error("ack without load");
endmodule // slave_checker
bind i2c_slave_addr_and_clock_stretch slave_checker slave_checker_inst (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .SCL_I(SCL_I), .SCL_OE_O(SCL_OE_O),
  .SDA_OE_O(SDA_OE_O), .BUF_RD_I(BUF_RD_I), .IRQ_CLR_I(IRQ_CLR_I),
  .OWN_ADDRESS_WR_I(OWN_ADDRESS_WR_I), .OWN_ADDRESS_I(OWN_ADDRESS_I),
  .RX_DATA_O(RX_DATA_O), .BUFFER_FULL_O(BUFFER_FULL_O), .OVERFLOW_O(OVERFLOW_O),
  .IRQ_FLAG_O(IRQ_FLAG_O), .UPDATE_ADDRESS_O(UPDATE_ADDRESS_O),
  .READ_WRITE_O(READ_WRITE_O), .CLOCK_RELEASE_O(CLOCK_RELEASE_O),
  .OWN_ADDRESS_O(OWN_ADDRESS_O)
);
`default_nettype wire

// file: bus_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Bus master model
// ****
module bus_master_model (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  import slave_pkg::*;
  initial begin
    scl_oe_o = 1'h0;
    sda_oe_o = 1'h0;
  end
  task automatic gap();
    repeat (50) @(posedge clk_i);
  endtask
  // Free the clock, wait up to 9000 cycles for a stretch to end, then keep it high
  task automatic rise();
    scl_oe_o <= 1'h0;
    for (int i = 0; i < 9000 && scl_i !== 1'h1; i++)
      @(posedge clk_i);
    gap();
  endtask
  task automatic fall();
    scl_oe_o <= 1'h1;
    gap();
  endtask
  task automatic start();
    sda_oe_o <= 1'h0;
    gap();
    rise();
    sda_oe_o <= 1'h1;
    gap();
    fall();
  endtask
  task automatic stop();
    sda_oe_o <= 1'h1;
    gap();
    rise();
    sda_oe_o <= 1'h0;
    gap();
  endtask
  task automatic put(input logic b);
    sda_oe_o <= ~b;
    gap();
    rise();
    fall();
  endtask
  task automatic get(output logic b);
    sda_oe_o <= 1'h0;
    gap();
    rise();
    b = sda_i;
    fall();
  endtask
  task automatic wbyte(input byte_t d, output logic a);
    for (int i = 7; i >= 0; i--)
      put(d[i]);
    get(a);
  endtask
  task automatic rbyte(input logic a, output byte_t d);
    for (int i = 7; i >= 0; i--)
      get(d[i]);
    put(a);
  endtask
endmodule // bus_master_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import slave_pkg::*;
  localparam logic [5:0] m_own = 6'h20, m_txw = 6'h10, m_rd = 6'h08;
  localparam logic [5:0] m_iclr = 6'h04, m_rel = 6'h02, m_oclr = 6'h01;
  localparam byte_t hi_w = {5'h1E, 2'h1, 1'h0};
  localparam byte_t hi_r = {5'h1E, 2'h1, 1'h1};
  logic clk_sys = 1'h0, link_clk = 1'h0, rst = 1'h1, ten_bit = 1'h0, stretch_en = 1'h0;
  logic own_wr = 1'h0, tx_wr = 1'h0, buf_rd = 1'h0, irq_clr = 1'h0, ovf_clr = 1'h0;
  logic rel_set = 1'h0, scl_o, sda_o;
  byte_t own_d = 8'h00, tx_d = 8'h00, rx_data, own_q, rd;
  logic scl, sda, m_scl_oe, m_sda_oe, scl_oe, sda_oe, bf, ovf, irq, ua, rw, clock_release_bit, ack;
  int failures = 0, comparisons = 0, cycles = 0;
  // ****
  // Clocks, wires and instances
  // ****
  always #2.5 clk_sys = ~clk_sys;
  initial begin
    #1.3;
    forever #7.5 link_clk = ~link_clk;
  end
  assign scl = ~(m_scl_oe | scl_oe);
  assign sda = ~(m_sda_oe | sda_oe);
  i2c_slave_addr_and_clock_stretch i2c_slave_addr_and_clock_stretch_inst (
    .CLK_SYS_I(clk_sys), .RST_I(rst), .LINK_CLK_I(link_clk), .SCL_I(scl), .SDA_I(sda),
    .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .TEN_BIT_MODE_I(ten_bit),
    .STRETCH_ENABLE_I(stretch_en), .OWN_ADDRESS_I(own_d), .OWN_ADDRESS_WR_I(own_wr),
    .TX_DATA_I(tx_d), .TX_WR_I(tx_wr), .BUF_RD_I(buf_rd), .IRQ_CLR_I(irq_clr),
    .OVERFLOW_CLR_I(ovf_clr), .CLOCK_RELEASE_SET_I(rel_set), .RX_DATA_O(rx_data),
    .BUFFER_FULL_O(bf), .OVERFLOW_O(ovf), .IRQ_FLAG_O(irq), .UPDATE_ADDRESS_O(ua),
    .READ_WRITE_O(rw), .CLOCK_RELEASE_O(clock_release_bit), .OWN_ADDRESS_O(own_q));
  bus_master_model bus_master_model_inst (.clk_i(clk_sys), .scl_i(scl), .sda_i(sda),
    .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
  // ****
  // Tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sw(input logic [5:0] m, input byte_t d);
    @(posedge clk_sys);
    {own_wr, tx_wr, buf_rd, irq_clr, rel_set, ovf_clr} <= m;
    own_d <= d;
    tx_d <= d;
    @(posedge clk_sys);
    {own_wr, tx_wr, buf_rd, irq_clr, rel_set, ovf_clr} <= 6'h00;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 2000 && irq !== 1'h1; i++)
      @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    check(irq, 16'h0001);
  endtask
  task automatic wr(input byte_t d, input logic a);
    bus_master_model_inst.wbyte(d, ack);
    check(ack, a);
  endtask
  task automatic rdb(input logic a, input byte_t exp);
    bus_master_model_inst.rbyte(a, rd);
    check(rd, exp);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    stretch_en <= 1'h1;
    repeat (8) @(posedge clk_sys);
    sw(m_own, 8'hA4);
    check(own_q, 8'hA4);
    bus_master_model_inst.start();
    wr(8'hA4, 1'h0);
    wait_irq();
    check({rx_data, bf, rw, clock_release_bit, scl_oe}, {8'hA4, 4'h9});
    check({scl_o, sda_o}, 2'h0);
    sw(m_rd | m_iclr | m_rel, 8'h00);
    check({bf, irq, clock_release_bit, scl_oe}, 4'h2);
    wr(8'h5A, 1'h0);
    wait_irq();
    check({rx_data, clock_release_bit, scl_oe}, {8'h5A, 2'h1});
    sw(m_iclr | m_rel, 8'h00);
    wr(8'h3C, 1'h1);
    wait_irq();
    check({ovf, rx_data}, {1'h1, 8'h5A});
    sw(m_rd | m_iclr | m_rel | m_oclr, 8'h00);
    check({ovf, bf}, 2'h0);
    bus_master_model_inst.stop();
    bus_master_model_inst.start();
    wr(8'hA6, 1'h1);
    repeat (100) @(posedge clk_sys);
    check(irq, 16'h0000);
    bus_master_model_inst.stop();
    $display("seven-bit write test done");
    stretch_en <= 1'h0;
    bus_master_model_inst.start();
    wr(8'hA4, 1'h0);
    wait_irq();
    check({bf, clock_release_bit, scl_oe}, 3'h6);
    sw(m_rd | m_iclr, 8'h00);
    wr(8'h11, 1'h0);
    wait_irq();
    check(rx_data, 8'h11);
    sw(m_rd | m_iclr, 8'h00);
    bus_master_model_inst.stop();
    bus_master_model_inst.start();
    wr(8'hA5, 1'h0);
    wait_irq();
    check({rx_data, rw, clock_release_bit, scl_oe}, {8'hA5, 3'h5});
    sw(m_rd | m_iclr, 8'h00);
    sw(m_txw, 8'hC3);
    check({bf, scl_oe}, 2'h3);
    sw(m_rel, 8'h00);
    rdb(1'h0, 8'hC3);
    wait_irq();
    check({bf, clock_release_bit, scl_oe}, 3'h1);
    sw(m_txw, 8'h81);
    sw(m_rel | m_iclr, 8'h00);
    rdb(1'h1, 8'h81);
    wait_irq();
    check({rw, bf, scl_oe}, 3'h0);
    bus_master_model_inst.stop();
    $display("seven-bit read test done");
    ten_bit <= 1'h1;
    stretch_en <= 1'h1;
    sw(m_own | m_iclr, hi_w);
    bus_master_model_inst.start();
    wr(hi_w, 1'h0);
    wait_irq();
    check({ua, bf, clock_release_bit, scl_oe}, 4'hF);
    sw(m_own | m_rd | m_iclr, 8'h34);
    check(own_q, 8'h34);
    check({ua, scl_oe}, 2'h0);
    wr(8'h34, 1'h0);
    wait_irq();
    check({ua, rx_data}, {1'h1, 8'h34});
    sw(m_own | m_rd | m_iclr, hi_w);
    wr(8'h77, 1'h0);
    wait_irq();
    check({rx_data, clock_release_bit, scl_oe}, {8'h77, 2'h1});
    sw(m_rd | m_iclr | m_rel, 8'h00);
    bus_master_model_inst.start();
    wr(hi_r, 1'h0);
    wait_irq();
    check({ua, bf, rw, clock_release_bit, scl_oe}, 5'h0D);
    sw(m_rd | m_iclr, 8'h00);
    sw(m_txw, 8'h9E);
    sw(m_rel, 8'h00);
    rdb(1'h1, 8'h9E);
    wait_irq();
    check(rw, 16'h0000);
    sw(m_iclr, 8'h00);
    bus_master_model_inst.stop();
    $display("ten-bit test done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
